// File: fsps_pkg.sv
/*
 * Constants for the flash self-programming sequencer: control register
 * offset and bit layout, command codes, timing windows and page geometry.
 * Assumes a 100 MHz core clock and a 16-bit word-addressed program memory.
 */
package fsps_pkg;

    // Register port
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;

    // self_prog_ctrl bit positions
    localparam int          BIT_SPM_EN      = 0;
    localparam int          BIT_PG_ERASE    = 1;
    localparam int          BIT_PG_WRITE    = 2;
    localparam int          BIT_LOCK_SEL    = 3;
    localparam int          BIT_RWW_REEN    = 4;
    localparam int          BIT_SIG_SEL     = 5;
    localparam int          BIT_RWW_BUSY    = 6;
    localparam int          BIT_IRQ_EN      = 7;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Command codes in bits 5..0 (bit 7 ignored, bit 6 read-only)
    localparam logic [5:0]  CMD_PAGE_ERASE  = 6'h03;
    localparam logic [5:0]  CMD_PAGE_LOAD   = 6'h01;
    localparam logic [5:0]  CMD_PAGE_WRITE  = 6'h05;
    localparam logic [5:0]  CMD_LOCK_SET    = 6'h09;
    localparam logic [5:0]  CMD_RWW_REEN    = 6'h11;
    localparam logic [5:0]  CMD_SIG_READ    = 6'h21;
    localparam logic [5:0]  CMD_MASK        = 6'h3f;

    // Windows after the control write, in cycles
    localparam logic [2:0]  STORE_WINDOW    = 3'd4;
    localparam logic [2:0]  LOAD_WINDOW     = 3'd3;

    // Page geometry: Z is a byte address, word = Z[7:1], page = Z[16:8]
    localparam int          Z_W             = 17;
    localparam int          WORD_LSB        = 1;
    localparam int          WORD_W          = 7;
    localparam int          PAGE_LSB        = 8;
    localparam int          PAGE_W          = 9;
    localparam int          PAGE_WORDS      = 128;
    localparam logic [8:0]  NO_RWW_REGION_FIRST_PAGE = 9'h1e0;
    localparam logic [15:0] ERASED_WORD     = 16'hffff;

    // Special read addresses
    localparam logic [16:0] Z_FUSE_LOW      = 17'h00000;
    localparam logic [16:0] Z_LOCK          = 17'h00001;
    localparam logic [16:0] Z_FUSE_EXT      = 17'h00002;
    localparam logic [16:0] Z_FUSE_HIGH     = 17'h00003;
    localparam logic [16:0] Z_SIG_1         = 17'h00000;
    localparam logic [16:0] Z_CAL           = 17'h00001;
    localparam logic [16:0] Z_SIG_2         = 17'h00002;
    localparam logic [16:0] Z_SIG_3         = 17'h00004;
    localparam logic [7:0]  RESERVED_BYTE   = 8'hff;
    localparam logic [5:0]  LOCK_FIELD      = 6'h3f;
    localparam logic [7:0]  LOCK_TOP_BITS   = 8'hc0;

    // Programming time
    localparam real         CLK_PERIOD_NS   = 10.0;
    localparam real         OP_MIN_TIME_MS  = 3.7;
    localparam real         OP_MAX_TIME_MS  = 4.5;
    localparam int          OP_MIN_CYCLES   =
        int'($ceil(OP_MIN_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int          OP_MAX_CYCLES   =
        int'($floor(OP_MAX_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int          OP_CNT_W        = 20;

    typedef enum logic [1:0] {
        FSPS_OP_NONE,
        FSPS_OP_ERASE,
        FSPS_OP_WRITE,
        FSPS_OP_LOCK
    } fsps_op_type;

endpackage : fsps_pkg

// File: fsps_sequencer.sv
/*
 * Flash self-programming sequencer: control register, timed command
 * windows, temporary page buffer, programming timer, region blocking,
 * and fuse/lock/signature reads.
 * Assumes the core gives one-cycle store and load strobes on this clock,
 * and that the flash array consumes the start pulses and buffer port.
 */
`timescale 1ns/1ps

// Overview of operation
// - Ctrl code X0000011 then store within four cycles erases the page.
// - Erase takes the page only from the page field of Z.
// - Erase in READ_WHILE_WRITE_REGION keeps NO_RWW_REGION readable; erase in NO_RWW_REGION halts the core.
// - Code 00000001 then store loads R1:R0 into buffer at word field.
// - Buffer clears after page write, on READ_WHILE_WRITE_REGION re-enable, and on reset.
// - An EEPROM write during buffer loading discards the loaded words.
// - Code X0000101 then store writes the buffer into the Z page.
// - Write in READ_WHILE_WRITE_REGION keeps NO_RWW_REGION readable; write in NO_RWW_REGION halts the core.
// - Interrupt stays asserted while enabled and enable bit is clear.
// - READ_WHILE_WRITE_REGION reads are blocked during every erase and write.
// - READ_WHILE_WRITE_REGION busy flag holds until software writes READ_WHILE_WRITE_REGION re-enable.
// - Code X0001001 then store programs lock bits zero in R0 5..0.
// - Whole flash stays readable during lock programming; Z ignored.
// - EEPROM write in progress refuses all programming and fuse reads.
// - Lock select, Z 0x0001, load within three cycles returns locks.
// - Z 0x0000, 0x0003, 0x0002 return fuse low, high, extended bytes.
// - Lock select and enable self-clear on read or window timeout.
// - Programmed fuse and lock bits read 0, unprogrammed read 1.
// - Signature select returns signature, calibration or reserved byte.
// - Signature select and enable self-clear on read or timeout.
// - Each erase, write or lock operation lasts 3.7 to 4.5 ms.
// - 128-word pages; Z bits 7..1 pick the word, bits 16..8 the page.
module fsps_sequencer
    import fsps_pkg::*;
#(
    parameter int unsigned OP_CYCLES = OP_MIN_CYCLES,
    parameter logic [7:0]  FUSE_LOW  = 8'h62,
    parameter logic [7:0]  FUSE_HIGH = 8'h99,
    parameter logic [7:0]  FUSE_EXT  = 8'hff,
    parameter logic [7:0]  LOCK_INIT = 8'hff,
    parameter logic [7:0]  SIG_1     = 8'h5a, // arbitrary identity value
    parameter logic [7:0]  SIG_2     = 8'h3c, // arbitrary identity value
    parameter logic [7:0]  SIG_3     = 8'h0f, // arbitrary identity value
    parameter logic [7:0]  CAL_BYTE  = 8'h80
) (
    input  wire logic                      clock,
    input  wire logic                      rst_n,

    // Register port
    input  wire logic [fsps_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,

    // Core instruction strobes
    input  wire logic                      store_exec,
    input  wire logic                      load_exec,
    input  wire logic [fsps_pkg::Z_W-1:0]  z_ptr,
    input  wire logic [7:0]                r0_data,
    input  wire logic [7:0]                r1_data,
    input  wire logic                      eeprom_write_busy,

    // Special read answer
    output logic                           special_rd_valid,
    output logic      [7:0]                special_rd_data,
    output logic                           special_rd_active,

    // Flash array side
    output logic                           flash_erase_start,
    output logic                           flash_write_start,
    output logic      [fsps_pkg::PAGE_W-1:0] flash_page,
    input  wire logic [fsps_pkg::WORD_W-1:0] buf_rd_idx,
    output logic      [15:0]               buf_rd_data,
    output logic      [7:0]                lock_bits,

    // Core control
    output logic                           rww_read_block,
    output logic                           cpu_halt,
    output logic                           irq
);
    import fsps_pkg::*;

    // Control
    logic [5:0]          cmd_q;
    logic                spm_en_q;
    logic                irq_en_q;
    logic                rww_busy_q;
    logic [2:0]          win_q;

    // Operation
    fsps_op_type         op_q;
    logic [OP_CNT_W-1:0] op_cnt_q;
    logic                op_no_rww_region_q;
    logic [PAGE_W-1:0]   page_q;

    // Lock
    logic [7:0]          lock_q;
    logic [5:0]          lock_new_q;

    // Buffer
    logic                loading_q;
    logic [15:0]         buf_q [PAGE_WORDS];

    // Reads
    logic [7:0]          rdata_q;
    logic                sp_valid_q;
    logic [7:0]          sp_data_q;

    // Decode
    logic                ctrl_wr;
    logic                cmd_wr;
    logic                reen_wr;
    logic                armed;
    logic                store_ok;
    logic                load_ok;
    logic                win_lapse;

    // Strobes
    logic                op_busy;
    logic                op_done;
    logic                do_erase;
    logic                do_write;
    logic                do_lock;
    logic                do_load;
    logic                buf_clear;

    // Fields
    logic [PAGE_W-1:0]   z_page;
    logic [WORD_W-1:0]   z_word;
    logic [OP_CNT_W-1:0] op_last;
    logic [7:0]          sp_byte;

    assign z_page  = z_ptr[PAGE_LSB +: PAGE_W];
    assign z_word  = z_ptr[WORD_LSB +: WORD_W];

    // Timer
    assign op_last = OP_CNT_W'(OP_CYCLES - 1);
    assign op_busy = (op_q != FSPS_OP_NONE);
    assign op_done = op_busy && (op_cnt_q == op_last);

    // Register write decode; commands refused while EEPROM or flash busy
    assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFFSET);
    assign cmd_wr  = ctrl_wr && reg_wdata[BIT_SPM_EN] && !op_busy
                     && !eeprom_write_busy;
    assign reen_wr = cmd_wr
        && ((reg_wdata[5:0] & CMD_MASK) == CMD_RWW_REEN);

    // Timed window after the control write
    assign armed     = spm_en_q && !op_busy;
    assign store_ok  = armed && store_exec && (win_q <= STORE_WINDOW)
                       && !eeprom_write_busy;
    assign load_ok   = armed && load_exec && (win_q <= LOAD_WINDOW)
                       && (cmd_q == CMD_LOCK_SET || cmd_q == CMD_SIG_READ)
                       && !(cmd_q == CMD_LOCK_SET && eeprom_write_busy);

    // Window lapse
    assign win_lapse = armed && !store_exec && !load_exec && (
        (cmd_q == CMD_SIG_READ && win_q == LOAD_WINDOW) ||
        (cmd_q != CMD_SIG_READ && win_q == STORE_WINDOW));

    // Store by command
    assign do_erase = store_ok && (cmd_q == CMD_PAGE_ERASE);
    assign do_load  = store_ok && (cmd_q == CMD_PAGE_LOAD);
    assign do_write = store_ok && (cmd_q == CMD_PAGE_WRITE);
    assign do_lock  = store_ok && (cmd_q == CMD_LOCK_SET);

    // Buffer clear sources
    assign buf_clear = (op_done && op_q == FSPS_OP_WRITE)
                       || reen_wr
                       || (loading_q && eeprom_write_busy);

    // Control register fields and self-clearing enable
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q    <= CTRL_RESET[5:0];
            spm_en_q <= CTRL_RESET[BIT_SPM_EN];
        end else if (cmd_wr && !reen_wr) begin
            cmd_q    <= reg_wdata[5:0];
            spm_en_q <= 1'b1;
        end else if (op_done) begin
            cmd_q    <= CTRL_RESET[5:0];
            spm_en_q <= 1'b0;
        end else if (do_load || load_ok || win_lapse) begin
            cmd_q    <= CTRL_RESET[5:0];
            spm_en_q <= 1'b0;
        end else if (do_erase || do_write || do_lock) begin
            spm_en_q <= 1'b1;
        end
    end

    // Interrupt enable bit, writable at any time
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= CTRL_RESET[BIT_IRQ_EN];
        end else if (ctrl_wr) begin
            irq_en_q <= reg_wdata[BIT_IRQ_EN];
        end
    end

    // Window counter: cycle 1 is the cycle after the control write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            win_q <= 3'd0;
        end else if (cmd_wr && !reen_wr) begin
            win_q <= 3'd1;
        end else if (armed && win_q <= STORE_WINDOW) begin
            win_q <= win_q + 3'd1;
        end
    end

    // READ_WHILE_WRITE_REGION busy: set at erase or write start, held until re-enable
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rww_busy_q <= 1'b0;
        end else if (do_erase || do_write) begin
            rww_busy_q <= 1'b1;
        end else if (reen_wr && !op_busy) begin
            rww_busy_q <= 1'b0;
        end
    end

    // Programming operation and its timer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_q      <= FSPS_OP_NONE;
            op_cnt_q  <= '0;
            op_no_rww_region_q <= 1'b0;
            page_q    <= '0;
        end else if (do_erase || do_write) begin
            op_q      <= do_erase ? FSPS_OP_ERASE : FSPS_OP_WRITE;
            op_cnt_q  <= '0;
            op_no_rww_region_q <= (z_page >= NO_RWW_REGION_FIRST_PAGE);
            page_q    <= z_page;
        end else if (do_lock) begin
            op_q      <= FSPS_OP_LOCK;
            op_cnt_q  <= '0;
            op_no_rww_region_q <= 1'b0;
        end else if (op_done) begin
            op_q      <= FSPS_OP_NONE;
            op_no_rww_region_q <= 1'b0;
        end else if (op_busy) begin
            op_cnt_q  <= op_cnt_q + 1'b1;
        end
    end

    // Lock bits: programmed bits only go to zero at the end of the op
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_q     <= LOCK_INIT;
            lock_new_q <= LOCK_FIELD;
        end else if (do_lock) begin
            lock_new_q <= r0_data[5:0];
        end else if (op_done && op_q == FSPS_OP_LOCK) begin
            lock_q     <= {lock_q[7:6], lock_q[5:0] & lock_new_q};
        end
    end

    // Loading marker for the EEPROM discard
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loading_q <= 1'b0;
        end else if (do_load) begin
            loading_q <= 1'b1;
        end else if (buf_clear) begin
            loading_q <= 1'b0;
        end
    end

    // Temporary page buffer, one word per entry
    for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_buf
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                buf_q[i] <= ERASED_WORD;
            end else if (do_load && z_word == WORD_W'(i)) begin
                buf_q[i] <= {r1_data, r0_data};
            end else if (buf_clear) begin
                buf_q[i] <= ERASED_WORD;
            end
        end
    end

    // Special byte selection for lock, fuse and signature reads
    always_comb begin
        sp_byte = RESERVED_BYTE;
        if (cmd_q == CMD_LOCK_SET) begin
            // Locks and fuses
            if (z_ptr == Z_LOCK) begin
                sp_byte = lock_q;
            end else if (z_ptr == Z_FUSE_LOW) begin
                sp_byte = FUSE_LOW;
            end else if (z_ptr == Z_FUSE_HIGH) begin
                sp_byte = FUSE_HIGH;
            end else if (z_ptr == Z_FUSE_EXT) begin
                sp_byte = FUSE_EXT;
            end
        end else begin
            // Signature row
            if (z_ptr == Z_SIG_1) begin
                sp_byte = SIG_1;
            end else if (z_ptr == Z_SIG_2) begin
                sp_byte = SIG_2;
            end else if (z_ptr == Z_SIG_3) begin
                sp_byte = SIG_3;
            end else if (z_ptr == Z_CAL) begin
                sp_byte = CAL_BYTE;
            end
        end
    end

    // Special read answer, one cycle after the load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sp_valid_q <= 1'b0;
            sp_data_q  <= 8'h00;
        end else begin
            sp_valid_q <= load_ok;
            if (load_ok) begin
                sp_data_q <= sp_byte;
            end
        end
    end

    // Register read data, one cycle after the read strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == CTRL_OFFSET) begin
                rdata_q <= {irq_en_q, rww_busy_q, cmd_q[5:1], spm_en_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // Buffer read port for the flash array
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buf_rd_data <= ERASED_WORD;
        end else begin
            buf_rd_data <= buf_q[buf_rd_idx];
        end
    end

    // Start pulses toward the flash array
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flash_erase_start <= 1'b0;
            flash_write_start <= 1'b0;
        end else begin
            flash_erase_start <= do_erase;
            flash_write_start <= do_write;
        end
    end

    // Outputs
    assign reg_rdata         = rdata_q;
    assign special_rd_valid  = sp_valid_q;
    assign special_rd_data   = sp_data_q;
    assign special_rd_active = load_ok;
    assign flash_page        = page_q;
    assign lock_bits         = lock_q;

    // Status
    assign rww_read_block    = (op_q == FSPS_OP_ERASE)
                               || (op_q == FSPS_OP_WRITE);
    assign cpu_halt          = op_busy && op_no_rww_region_q;
    assign irq               = irq_en_q && !spm_en_q;

endmodule : fsps_sequencer

// File: fsps_core_model.sv
/*
 * Core-side model: issues store and load program-memory strobes and the
 * EEPROM busy level towards the sequencer.
 * Assumes one shared clock; tasks are entered right after a rising edge.
 */
`timescale 1ns/1ps
module fsps_core_model
    import fsps_pkg::*;
(
    input  wire logic                    clock,
    output logic                         store_exec,
    output logic                         load_exec,
    output logic [fsps_pkg::Z_W-1:0]     z_ptr,
    output logic [7:0]                   r0_data,
    output logic [7:0]                   r1_data,
    output logic                         eeprom_write_busy
);
    // Idle values at time zero
    initial begin
        store_exec = 1'b0;
        load_exec = 1'b0;
        z_ptr = '0;
        r0_data = 8'h00;
        r1_data = 8'h00;
        eeprom_write_busy = 1'b0;
    end

    // One-cycle store; operands scrambled once released
    task automatic spm(input logic [16:0] z, input logic [15:0] r);
        z_ptr <= z;
        {r1_data, r0_data} <= r;
        store_exec <= 1'b1;
        @(posedge clock);
        store_exec <= 1'b0;
        z_ptr <= ~z;
        {r1_data, r0_data} <= ~r;
    endtask : spm

    // One-cycle load with the byte address in Z
    task automatic lpm(input logic [16:0] z);
        z_ptr <= z;
        load_exec <= 1'b1;
        @(posedge clock);
        load_exec <= 1'b0;
        z_ptr <= ~z;
    endtask : lpm

    // EEPROM write in progress level
    task automatic ee(input logic b);
        eeprom_write_busy <= b;
    endtask : ee
endmodule : fsps_core_model

// File: fsps_sequencer_sva.sv
/*
 * Port-level checker for the flash self-programming sequencer.
 * Assumes it is bound into every sequencer instance with its OP_CYCLES.
 */
`timescale 1ns/1ps
module fsps_sequencer_chk
    import fsps_pkg::*;
#(
    parameter int unsigned OP_CYCLES = 20
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       store_exec,
    input wire logic       load_exec,
    input wire logic       eeprom_write_busy,
    input wire logic       special_rd_valid,
    input wire logic       special_rd_active,
    input wire logic       flash_erase_start,
    input wire logic       flash_write_start,
    input wire logic [8:0] flash_page,
    input wire logic       rww_read_block,
    input wire logic       cpu_halt,
    input wire logic       irq
);
    logic [19:0] busy_cnt_q;

    // Length of the current blocked interval
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= rww_read_block ? busy_cnt_q + 20'd1 : '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    start_cause_a: assert property (
        (flash_erase_start || flash_write_start) |->
        $past(store_exec) && !$past(eeprom_write_busy))
        else $error("program start without an accepted store");
    start_pulse_a: assert property (
        flash_write_start |=> !flash_write_start && !flash_erase_start)
        else $error("write start longer than one cycle");
    block_start_a: assert property (
        (flash_erase_start || flash_write_start) |-> rww_read_block)
        else $error("region not blocked at program start");
    halt_page_a: assert property (
        $rose(rww_read_block) |->
        cpu_halt == (flash_page >= NO_RWW_REGION_FIRST_PAGE))
        else $error("halt does not match programmed region");
    halt_block_a: assert property (
        cpu_halt |-> rww_read_block)
        else $error("core halted outside an operation");
    irq_busy_a: assert property (
        rww_read_block |-> !irq)
        else $error("interrupt raised while operation runs");
    op_time_a: assert property (
        $fell(rww_read_block) |->
        busy_cnt_q >= OP_CYCLES - 1 && busy_cnt_q <= OP_CYCLES + 1)
        else $error("operation length out of range");
    special_rd_a: assert property (
        special_rd_active |-> (load_exec && !eeprom_write_busy)
        ##1 special_rd_valid)
        else $error("special read not answered");
    valid_cause_a: assert property (
        special_rd_valid |-> $past(special_rd_active))
        else $error("special read answer without load");

    cover property ($rose(cpu_halt));
    cover property (flash_erase_start && !cpu_halt);
    cover property (special_rd_valid);
endmodule : fsps_sequencer_chk

bind fsps_sequencer fsps_sequencer_chk #(.OP_CYCLES(OP_CYCLES))
    fsps_sequencer_chk_inst (
    .clock(clock), .rst_n(rst_n), .store_exec(store_exec),
    .load_exec(load_exec), .eeprom_write_busy(eeprom_write_busy),
    .special_rd_valid(special_rd_valid),
    .special_rd_active(special_rd_active),
    .flash_erase_start(flash_erase_start),
    .flash_write_start(flash_write_start), .flash_page(flash_page),
    .rww_read_block(rww_read_block), .cpu_halt(cpu_halt), .irq(irq));

// File: fsps_sequencer_tb_top.sv
/*
 * Self-checking testbench for the sequencer with a core model.
 * Assumes a 100 MHz clock and a shortened programming time.
 */
`timescale 1ns/1ps
module fsps_sequencer_tb_top;
    import fsps_pkg::*;
    localparam int OPC = 20;
    localparam logic [7:0] FL = 8'h6e, FH = 8'hd9, FE = 8'hfd, CB = 8'h7c;
    localparam logic [7:0] S1 = 8'h11, S2 = 8'h22, S3 = 8'h33; // arbitrary
    logic        clock, rst_n, reg_wr, reg_rd, store_exec, load_exec;
    logic        eeprom_write_busy, special_rd_valid, special_rd_active;
    logic        flash_erase_start, flash_write_start;
    logic        rww_read_block, cpu_halt, irq;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, r0_data, r1_data;
    logic [7:0]  special_rd_data, lock_bits;
    logic [16:0] z_ptr;
    logic [8:0]  flash_page;
    logic [6:0]  buf_rd_idx;
    logic [15:0] buf_rd_data;
    int          n_mismatch = 0;
    int          checked = 0;

    fsps_sequencer #(.OP_CYCLES(OPC), .FUSE_LOW(FL), .FUSE_HIGH(FH),
        .FUSE_EXT(FE), .SIG_1(S1), .SIG_2(S2), .SIG_3(S3), .CAL_BYTE(CB))
    fsps_sequencer_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .store_exec(store_exec),
        .load_exec(load_exec), .z_ptr(z_ptr), .r0_data(r0_data),
        .r1_data(r1_data), .eeprom_write_busy(eeprom_write_busy),
        .special_rd_valid(special_rd_valid),
        .special_rd_data(special_rd_data),
        .special_rd_active(special_rd_active),
        .flash_erase_start(flash_erase_start),
        .flash_write_start(flash_write_start), .flash_page(flash_page),
        .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data),
        .lock_bits(lock_bits), .rww_read_block(rww_read_block),
        .cpu_halt(cpu_halt), .irq(irq));

    fsps_core_model fsps_core_model_inst (.clock(clock),
        .store_exec(store_exec), .load_exec(load_exec), .z_ptr(z_ptr),
        .r0_data(r0_data), .r1_data(r1_data),
        .eeprom_write_busy(eeprom_write_busy));

    task automatic close_out;
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] v);
        reg_addr <= CTRL_OFFSET;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data is taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        chk(reg_rdata, e);
    endtask : rd

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        chk(32'(n >= OPC - 2 && n <= OPC + 2), 32'd1);
    endtask : wait_irq

    task automatic bufchk(input logic [6:0] i, input logic [15:0] e);
        buf_rd_idx <= i;
        repeat (2) @(posedge clock);
        chk(buf_rd_data, e);
    endtask : bufchk

    task automatic t_erase(input logic [8:0] p);
        wr(8'h83);
        fsps_core_model_inst.spm({p, 8'h5b}, 16'h1234);
        @(posedge clock);
        chk(flash_erase_start, 1'b1);
        chk(flash_page, p);
        chk(cpu_halt, 32'(p >= NO_RWW_REGION_FIRST_PAGE));
        chk(rww_read_block, 1'b1);
        wait_irq;
        rd(CTRL_OFFSET, 8'hc0);
        wr(8'h11);
        repeat (4) @(posedge clock);
        rd(CTRL_OFFSET, 8'h00);
        chk(irq, 1'b0);
    endtask : t_erase

    task automatic t_write;
        wr(8'h01);
        fsps_core_model_inst.spm(17'h1e00a, 16'ha55a);
        bufchk(7'd5, 16'ha55a);
        wr(8'h85);
        fsps_core_model_inst.spm(17'h1e000, 16'h0000);
        @(posedge clock);
        chk(flash_write_start, 1'b1);
        chk({cpu_halt, flash_page}, {1'b1, 9'h1e0});
        wait_irq;
        bufchk(7'd5, ERASED_WORD);
        wr(8'h11);
    endtask : t_write

    task automatic t_eeprom;
        @(posedge clock);
        wr(8'h01);
        fsps_core_model_inst.spm(17'h00004, 16'hbeef);
        bufchk(7'd2, 16'hbeef);
        fsps_core_model_inst.ee(1'b1);
        @(posedge clock);
        bufchk(7'd2, ERASED_WORD);
        wr(8'h03);
        fsps_core_model_inst.spm(17'h00300, 16'h0000);
        wr(8'h09);
        chk({flash_erase_start, rww_read_block}, 2'b00);
        fsps_core_model_inst.lpm(Z_LOCK);
        @(posedge clock);
        chk(special_rd_valid, 1'b0);
        fsps_core_model_inst.ee(1'b0);
        repeat (4) @(posedge clock);
        wr(8'h01);
        fsps_core_model_inst.spm(17'h00006, 16'hc0de);
        wr(8'h11);
        bufchk(7'd3, ERASED_WORD);
    endtask : t_eeprom

    task automatic t_lock;
        wr(8'h09);
        fsps_core_model_inst.spm(Z_LOCK, 16'h00f6);
        @(posedge clock);
        chk({flash_erase_start, rww_read_block}, 2'b00);
        repeat (OPC + 4) @(posedge clock);
        chk(lock_bits, 8'hf6);
        wr(8'h09);
        repeat (4) @(posedge clock);
        fsps_core_model_inst.spm(Z_LOCK, 16'h0000);
        repeat (OPC + 4) @(posedge clock);
        chk(lock_bits, 8'hf6);
    endtask : t_lock

    // Loads in the last honoured window cycle, then one too late
    task automatic t_special;
        logic [16:0] zt [10];
        logic [7:0]  et [10];
        zt = '{Z_FUSE_LOW, Z_FUSE_HIGH, Z_FUSE_EXT, Z_LOCK, Z_SIG_1, Z_CAL,
            Z_SIG_2, Z_SIG_3, 17'h00006, Z_SIG_1};
        et = '{FL, FH, FE, 8'hf6, S1, CB, S2, S3, RESERVED_BYTE, S1};
        for (int i = 0; i < 10; i++) begin
            wr(i < 4 ? 8'h09 : 8'h21);
            repeat (i == 9 ? 3 : 2) @(posedge clock);
            fsps_core_model_inst.lpm(zt[i]);
            @(posedge clock);
            chk(special_rd_valid, 32'(i != 9));
            if (i != 9) chk(special_rd_data, et[i]);
            rd(CTRL_OFFSET, 8'h00);
        end
    endtask : t_special

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        close_out;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, buf_rd_idx} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk({lock_bits, buf_rd_data}, 24'hffffff);
        rd(CTRL_OFFSET, CTRL_RESET);
        rd(8'h40, 8'h00);
        t_erase(9'h003);
        t_erase(9'h1e0);
        t_write;
        t_eeprom;
        t_lock;
        t_special;
        close_out;
    end
endmodule : fsps_sequencer_tb_top
